/* core/mxmem_cfg.svh */
// Purpose: constants of the data-memory access block
// Assumes: 32-bit APB, one word per register
// Notes:   offsets are byte addresses
`ifndef MXMEM_CFG_SVH
`define MXMEM_CFG_SVH
// bus timing keeps its register index; its byte address is four times it
`define MXMEM_IDX_BUS_TIMING  10'h08e
`define MXMEM_OFF_BUS_TIMING  ({`MXMEM_IDX_BUS_TIMING, 2'b00})
`define MXMEM_OFF_PTR_SELECT  12'h0084
`define MXMEM_OFF_POWER_MGMT  12'h0088
`define MXMEM_OFF_PTR0        12'h0090
`define MXMEM_OFF_PTR1        12'h0094
`define MXMEM_OFF_STATUS      12'h0098
`define MXMEM_RST_BUS_TIMING  8'h01
`define MXMEM_RST_PTR_SELECT  8'h00
`define MXMEM_RST_POWER_MGMT  8'h00
`define MXMEM_BIT_SEL         0
`define MXMEM_BIT_ADJ         4
`define MXMEM_BIT_TGL         5
`define MXMEM_BIT_DIR0        6
`define MXMEM_BIT_DIR1        7
`define MXMEM_INT_TOP         16'h03ff
`define MXMEM_SYS_PER_MC      4
`define MXMEM_EXT_CLKS        4
`endif

/* core/mxmem_pkg.sv */
// Purpose: types of the data-memory access block
// Assumes: nothing
// Notes:   none
`default_nettype none
package mxmem_pkg;
  typedef enum logic [2:0] {
    MXMEM_OP_NONE, MXMEM_OP_INC, MXMEM_OP_MOVDP, MXMEM_OP_MOVC,
    MXMEM_OP_MOVX_RD, MXMEM_OP_MOVX_WR
  } mxmem_op_type;
  typedef enum logic [2:0] {
    MXMEM_ST_IDLE, MXMEM_ST_ALE, MXMEM_ST_SETUP, MXMEM_ST_STROBE,
    MXMEM_ST_HOLD, MXMEM_ST_DONE
  } mxmem_st_type;
endpackage
`default_nettype wire

/* core/mxmem_sram.sv */
// Purpose: on-chip data SRAM, one clock per access
// Assumes: synchronous write, registered read data
// Notes:   sized by parameters
`default_nettype none
module mxmem_sram #(
  parameter int AW = 10,
  parameter int DW = 8
) (
  input  wire logic          sys_clk_i,
  input  wire logic          en_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  always_ff @(posedge sys_clk_i) begin
    if (en_i) begin
      if (we_i) begin
        mem[addr_i] <= wdata_i;
      end
      rdata_o <= mem[addr_i];
    end
  end
endmodule
`default_nettype wire

/* core/mxmem_top.sv */
// Purpose: MOVX data memory, dual data pointer and external bus timing
// Assumes: core issues one op at a time and waits for op_done_o
// Notes:   page modes are not built; non-page bus only
// Functional notes
// - 1kB on-chip data SRAM mapped 0000h..03FFh
// - after reset internal SRAM is off; all MOVX go external
// - enable bits are power management register bits 1..0
// - enabled: in-range hits SRAM, above range goes external
// - on-chip SRAM access finishes in one system clock; MOVX reads here take two
// - INC DPTR steps active pointer; its direction bit picks decrement
// - active pointer chosen only by select bit 0
// - toggle enable flips select after the five pointer instructions
// - auto-adjust steps selected pointer after MOVC and MOVX
// - external cycles take four clocks, internal fetch one
// - page mode one: hit 1/2/4, miss 2/4/8 clocks
// - page mode two: data accesses always four clocks
// - latch strobe off on internal fetch unless option set
// - program store strobe only on external code fetches
// - stretch from bus timing register bits 2..0, used next access
// - each stretch machine cycle is four system clocks
// - stretch codes map to 0,1,2,3,7,8,9,10 cycles
// - stretch 0: MOVX completes in two basic memory cycles
// - stretch 1..3 add 1..3 stretch machine cycles
// - stretch 1: one clock extra setup, one extra hold
// - stretch 4..7: one machine cycle on latch, setup, hold, strobe
// - strobe width scales with clock divide setting; no divide setting is built, strobe width follows the stretch code only
// - stretch resets to 1
//
// The APB register port is this design's own decision.
`default_nettype none
`include "mxmem_cfg.svh"
module mxmem_top
  import mxmem_pkg::*;
#(
  parameter int AW = 16
) (
  input  wire logic          sys_clk_i,
  input  wire logic          rst_i,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          op_valid_i,
  input  wire logic [2:0]    op_code_i,
  input  wire logic [15:0]   op_data_i,
  input  wire logic [7:0]    op_wdata_i,
  input  wire logic          fetch_valid_i,
  input  wire logic          fetch_ext_i,
  input  wire logic          ale_internal_en_i,
  output logic               op_done_o,
  output logic      [7:0]    op_rdata_o,
  output logic      [15:0]   dptr_o,
  output logic               fetch_done_o,
  output logic      [AW-1:0] ext_addr_o,
  output logic      [7:0]    ext_data_o,
  output logic               ext_data_oe_o,
  input  wire logic [7:0]    ext_data_i,
  output logic               ale_o,
  output logic               rd_n_o,
  output logic               wr_n_o,
  output logic               program_store_strobe_n_o
);
  typedef struct packed {
    logic [7:0]   bus_timing;
    logic [7:0]   ptr_sel;
    logic [7:0]   pwr;
    logic [15:0]  ptr0;
    logic [15:0]  ptr1;
    mxmem_st_type st;
    logic [5:0]   cnt;
    logic [5:0]   setup_n;
    logic [5:0]   strobe_n;
    logic [5:0]   hold_n;
    logic         is_wr;
    logic         is_code;
    logic         int_pend;
    logic         op_taken;
    logic         fetch_taken;
    logic [AW-1:0] addr;
    logic [7:0]   wdata;
    logic [7:0]   rdata;
    logic         done;
    logic         fdone;
    logic         ale;
    logic         rd_n;
    logic         wr_n;
    logic         ps_n;
    logic         doe;
    logic [31:0]  prdata;
  } mxmem_state_type;

  mxmem_state_type r, next_r;
  logic [7:0] sram_rdata;
  logic       sram_en;
  logic       sram_we;

  // stretch code to inserted stretch machine cycles
  function automatic logic [3:0] stretch_cycles(input logic [2:0] code);
    case (code)
      3'b000:  stretch_cycles = 4'h0;
      3'b001:  stretch_cycles = 4'h1;
      3'b010:  stretch_cycles = 4'h2;
      3'b011:  stretch_cycles = 4'h3;
      3'b100:  stretch_cycles = 4'h7;
      3'b101:  stretch_cycles = 4'h8;
      3'b110:  stretch_cycles = 4'h9;
      default: stretch_cycles = 4'ha;
    endcase
  endfunction

  function automatic logic reg_hit(input logic [11:0] a,
                                   input logic [11:0] off);
    reg_hit = (a == off);
  endfunction

  wire logic       sel      = r.ptr_sel[`MXMEM_BIT_SEL];
  wire logic [15:0] act_ptr = sel ? r.ptr1 : r.ptr0;
  wire logic       dec      = sel ? r.ptr_sel[`MXMEM_BIT_DIR1]
                                  : r.ptr_sel[`MXMEM_BIT_DIR0];
  wire logic [15:0] stepped = dec ? act_ptr - 16'h0001
                                  : act_ptr + 16'h0001;
  wire logic       dmem_on  = |r.pwr[1:0];
  wire logic       apb_acc  = psel & penable;
  wire logic       mapped   = reg_hit(paddr, `MXMEM_OFF_BUS_TIMING)
                            | reg_hit(paddr, `MXMEM_OFF_PTR_SELECT)
                            | reg_hit(paddr, `MXMEM_OFF_POWER_MGMT)
                            | reg_hit(paddr, `MXMEM_OFF_PTR0)
                            | reg_hit(paddr, `MXMEM_OFF_PTR1)
                            | reg_hit(paddr, `MXMEM_OFF_STATUS);

  always_comb begin
    mxmem_op_type op;
    logic [3:0]   sc;
    logic         is_movx;
    logic         internal;
    op       = mxmem_op_type'(op_code_i);
    sc       = stretch_cycles(r.bus_timing[2:0]);
    is_movx  = (op == MXMEM_OP_MOVX_RD) || (op == MXMEM_OP_MOVX_WR);
    internal = dmem_on &&
               (act_ptr <= `MXMEM_INT_TOP);
    next_r   = r;
    next_r.done  = 1'b0;
    next_r.fdone = 1'b0;
    sram_en  = 1'b0;
    sram_we  = 1'b0;

    if (apb_acc && pwrite) begin
      if (reg_hit(paddr, `MXMEM_OFF_BUS_TIMING)) begin
        next_r.bus_timing = pwdata[7:0];
      end
      if (reg_hit(paddr, `MXMEM_OFF_PTR_SELECT)) begin
        next_r.ptr_sel = pwdata[7:0];
      end
      if (reg_hit(paddr, `MXMEM_OFF_POWER_MGMT)) begin
        next_r.pwr = pwdata[7:0];
      end
      if (reg_hit(paddr, `MXMEM_OFF_PTR0)) begin
        next_r.ptr0 = pwdata[15:0];
      end
      if (reg_hit(paddr, `MXMEM_OFF_PTR1)) begin
        next_r.ptr1 = pwdata[15:0];
      end
    end
    next_r.prdata = 32'h0000_0000;
    // loaded in the setup cycle so it stands through the access phase
    if (psel && !penable && !pwrite) begin
      if (reg_hit(paddr, `MXMEM_OFF_BUS_TIMING)) begin
        next_r.prdata = {24'h00_0000, r.bus_timing};
      end
      if (reg_hit(paddr, `MXMEM_OFF_PTR_SELECT)) begin
        next_r.prdata = {24'h00_0000, r.ptr_sel};
      end
      if (reg_hit(paddr, `MXMEM_OFF_POWER_MGMT)) begin
        next_r.prdata = {24'h00_0000, r.pwr};
      end
      if (reg_hit(paddr, `MXMEM_OFF_PTR0)) begin
        next_r.prdata = {16'h0000, r.ptr0};
      end
      if (reg_hit(paddr, `MXMEM_OFF_PTR1)) begin
        next_r.prdata = {16'h0000, r.ptr1};
      end
      if (reg_hit(paddr, `MXMEM_OFF_STATUS)) begin
        next_r.prdata = {26'h000_0000, 1'b0, dmem_on,
                         1'b0, r.st};
      end
    end

    // internal SRAM read data arrives one clock after the enable
    if (r.int_pend) begin
      next_r.int_pend = 1'b0;
      next_r.rdata    = sram_rdata;
      next_r.done     = 1'b1;
    end

    // a request is served once; the core drops it before the next one
    if (!op_valid_i) next_r.op_taken = 1'b0;
    if (!fetch_valid_i) next_r.fetch_taken = 1'b0;

    case (r.st)
      MXMEM_ST_IDLE: begin
        next_r.ale  = 1'b0;
        next_r.rd_n = 1'b1;
        next_r.wr_n = 1'b1;
        next_r.ps_n = 1'b1;
        next_r.doe  = 1'b0;
        if (op_valid_i && !r.op_taken && !r.int_pend) begin
          next_r.op_taken = 1'b1;
          if (is_movx && internal) begin
            sram_en         = 1'b1;
            sram_we         = (op == MXMEM_OP_MOVX_WR);
            next_r.int_pend = (op == MXMEM_OP_MOVX_RD);
            next_r.done     = (op == MXMEM_OP_MOVX_WR);
          end else if (is_movx) begin
            next_r.st      = MXMEM_ST_ALE;
            next_r.is_wr   = (op == MXMEM_OP_MOVX_WR);
            next_r.is_code = 1'b0;
            next_r.addr    = act_ptr[AW-1:0];
            next_r.wdata   = op_wdata_i;
            next_r.ale     = 1'b1;
            // base: latch one clock, setup, strobe and hold two each; stretch 0 totals two basic cycles
            next_r.cnt     = (sc >= 4'h7) ? 6'(1 + `MXMEM_SYS_PER_MC)
                                          : 6'd1;
            if (sc == 4'h0) begin
              next_r.setup_n  = 6'd2;
              next_r.strobe_n = 6'd2;
              next_r.hold_n   = 6'd2;
            end else if (sc <= 4'h3) begin
              next_r.setup_n  = 6'd3;
              next_r.hold_n   = 6'd3;
              next_r.strobe_n = 6'(`MXMEM_SYS_PER_MC * sc);
            end else begin
              // codes 4..7 grow latch, setup, hold and strobe by a cycle
              next_r.setup_n  = 6'(3 + `MXMEM_SYS_PER_MC);
              next_r.hold_n   = 6'(3 + `MXMEM_SYS_PER_MC);
              next_r.strobe_n = 6'(`MXMEM_SYS_PER_MC * (sc - 4'h3));
            end
          end else begin
            next_r.done = 1'b1;
          end
          case (op)
            MXMEM_OP_INC: begin
              if (sel) next_r.ptr1 = stepped;
              else next_r.ptr0 = stepped;
            end
            MXMEM_OP_MOVDP: begin
              if (sel) next_r.ptr1 = op_data_i;
              else next_r.ptr0 = op_data_i;
            end
            MXMEM_OP_MOVC, MXMEM_OP_MOVX_RD, MXMEM_OP_MOVX_WR: begin
              if (r.ptr_sel[`MXMEM_BIT_ADJ]) begin
                if (sel) next_r.ptr1 = stepped;
                else next_r.ptr0 = stepped;
              end
            end
            default: begin
            end
          endcase
          if (op != MXMEM_OP_NONE && r.ptr_sel[`MXMEM_BIT_TGL]) begin
            next_r.ptr_sel[`MXMEM_BIT_SEL] = ~sel;
          end
          if (apb_acc && pwrite &&
              reg_hit(paddr, `MXMEM_OFF_PTR_SELECT)) begin
            next_r.ptr_sel = pwdata[7:0];
          end
        end else if (fetch_valid_i && !r.fetch_taken) begin
          next_r.fetch_taken = 1'b1;
          if (fetch_ext_i) begin
            // external fetch: fixed four clocks, never stretched
            next_r.st       = MXMEM_ST_ALE;
            next_r.is_code  = 1'b1;
            next_r.is_wr    = 1'b0;
            next_r.addr     = op_data_i[AW-1:0];
            next_r.ale      = 1'b1;
            next_r.cnt      = 6'd1;
            next_r.setup_n  = 6'd1;
            next_r.strobe_n = 6'(`MXMEM_EXT_CLKS - 3);
            next_r.hold_n   = 6'd1;
          end else begin
            next_r.ale   = ale_internal_en_i;
            next_r.fdone = 1'b1;
          end
        end
      end
      MXMEM_ST_ALE: begin
        if (r.cnt <= 6'd1) begin
          next_r.ale = 1'b0;
          next_r.st  = MXMEM_ST_SETUP;
          next_r.cnt = r.setup_n;
          if (r.is_code) begin
            next_r.st   = MXMEM_ST_STROBE;
            next_r.cnt  = r.strobe_n;
            next_r.ps_n = 1'b0;
          end
        end else begin
          next_r.cnt = r.cnt - 6'd1;
        end
      end
      MXMEM_ST_SETUP: begin
        next_r.doe = r.is_wr;
        if (r.cnt <= 6'd1) begin
          next_r.st   = MXMEM_ST_STROBE;
          next_r.cnt  = r.strobe_n;
          next_r.rd_n = r.is_wr;
          next_r.wr_n = ~r.is_wr;
        end else begin
          next_r.cnt = r.cnt - 6'd1;
        end
      end
      MXMEM_ST_STROBE: begin
        if (r.cnt <= 6'd1) begin
          if (!r.is_wr) next_r.rdata = ext_data_i;
          next_r.rd_n = 1'b1;
          next_r.wr_n = 1'b1;
          next_r.ps_n = 1'b1;
          next_r.st   = MXMEM_ST_HOLD;
          next_r.cnt  = r.hold_n;
        end else begin
          next_r.cnt = r.cnt - 6'd1;
        end
      end
      MXMEM_ST_HOLD: begin
        if (r.cnt <= 6'd1) begin
          next_r.doe = 1'b0;
          next_r.st  = MXMEM_ST_DONE;
          if (r.is_code) begin
            // fetch ends here so the whole cycle stays four clocks
            next_r.st    = MXMEM_ST_IDLE;
            next_r.fdone = 1'b1;
          end
        end else begin
          next_r.cnt = r.cnt - 6'd1;
        end
      end
      MXMEM_ST_DONE: begin
        next_r.st = MXMEM_ST_IDLE;
        if (r.is_code) next_r.fdone = 1'b1;
        else next_r.done = 1'b1;
      end
      default: begin
        next_r.st = MXMEM_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      r            <= '0;
      r.st         <= MXMEM_ST_IDLE;
      r.bus_timing <= `MXMEM_RST_BUS_TIMING;
      r.ptr_sel    <= `MXMEM_RST_PTR_SELECT;
      r.pwr        <= `MXMEM_RST_POWER_MGMT;
      r.rd_n       <= 1'b1;
      r.wr_n       <= 1'b1;
      r.ps_n       <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  mxmem_sram #(.AW(10), .DW(8)) u_sram (
    .sys_clk_i (sys_clk_i),
    .en_i      (sram_en),
    .we_i      (sram_we),
    .addr_i    (act_ptr[9:0]),
    .wdata_i   (op_wdata_i),
    .rdata_o   (sram_rdata)
  );

  assign prdata        = r.prdata;
  assign pready        = 1'b1;
  assign pslverr       = apb_acc & ~mapped;
  assign op_done_o     = r.done;
  assign op_rdata_o    = r.rdata;
  assign dptr_o        = act_ptr;
  assign fetch_done_o  = r.fdone;
  assign ext_addr_o    = r.addr;
  assign ext_data_o    = r.wdata;
  assign ext_data_oe_o = r.doe;
  assign ale_o         = r.ale;
  assign rd_n_o        = r.rd_n;
  assign wr_n_o        = r.wr_n;
  assign program_store_strobe_n_o = r.ps_n;
endmodule
`default_nettype wire

/* verif/mxmem_ext_ram.sv */
// Purpose: external byte memory on the multiplexed data bus
// Assumes: strobes active low, address held through the strobe
// Notes:   slow mode answers two clocks into the read strobe
`default_nettype none
module mxmem_ext_ram (
  input  wire logic        sys_clk_i,
  input  wire logic        slow_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  data_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  output logic      [7:0]  data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  logic [7:0] last;
  logic [2:0] rd_cnt;
  logic       ready;
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
    last = 8'h00;
    rd_cnt = 3'd0;
  end
  assign ready = !rd_n_i && (!slow_i || rd_cnt >= 3'd2);
  // released bus shows the inverse of the last byte, never a stale copy
  assign data_o = ready ? mem[addr_i] : ~last;
  always @(posedge sys_clk_i) begin
    rd_cnt <= rd_n_i ? 3'd0 : (rd_cnt == 3'd7 ? rd_cnt : rd_cnt + 3'd1);
    if (ready) last <= mem[addr_i];
    if (!wr_n_i) mem[addr_i] <= data_i;
  end
endmodule
`default_nettype wire

/* verif/mxmem_top_monitor.sv */
// Purpose: boundary checks of the data-memory access block
// Assumes: core holds op and fetch requests until their done pulse
// Notes:   select and power registers are shadowed from APB writes
`default_nettype none
`include "mxmem_cfg.svh"
module mxmem_top_monitor (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        op_valid_i,
  input wire logic [2:0]  op_code_i,
  input wire logic        fetch_valid_i,
  input wire logic        fetch_ext_i,
  input wire logic        ale_internal_en_i,
  input wire logic        op_done_o,
  input wire logic [15:0] dptr_o,
  input wire logic        fetch_done_o,
  input wire logic        ale_o,
  input wire logic        rd_n_o,
  input wire logic        wr_n_o,
  input wire logic        program_store_strobe_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sel_q;
  logic [7:0] pwr_q;
  logic       dec;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sel_q <= 8'h00;
      pwr_q <= 8'h00;
    end else if (psel && penable && pwrite) begin
      if (paddr == `MXMEM_OFF_PTR_SELECT) sel_q <= pwdata[7:0];
      if (paddr == `MXMEM_OFF_POWER_MGMT) pwr_q <= pwdata[7:0];
    end
  end
  assign dec = sel_q[0] ? sel_q[7] : sel_q[6];
  property p_inc_step;
    $rose(op_valid_i) && op_code_i == 3'd1 && !sel_q[5] |=>
      dptr_o == $past(dptr_o) + (dec ? 16'hffff : 16'h0001);
  endproperty
  a_inc_step: assert property (p_inc_step)
    else $error("pointer step wrong");
  property p_int_wr;
    $rose(op_valid_i) && op_code_i == 3'd5 && pwr_q[1:0] != 2'b00 &&
      dptr_o <= 16'h03ff |=> op_done_o;
  endproperty
  a_int_wr: assert property (p_int_wr)
    else $error("internal write not done in one clock");
  property p_ext_movx;
    $rose(op_valid_i) && (op_code_i == 3'd4 || op_code_i == 3'd5) &&
      (pwr_q[1:0] == 2'b00 || dptr_o > 16'h03ff) |=>
      !op_done_o ##[1:24] !(rd_n_o && wr_n_o);
  endproperty
  a_ext_movx: assert property (p_ext_movx)
    else $error("data access did not go external");
  property p_int_fetch;
    $rose(fetch_valid_i) && !fetch_ext_i |=> fetch_done_o;
  endproperty
  a_int_fetch: assert property (p_int_fetch)
    else $error("internal fetch not one clock");
  property p_ext_fetch;
    $rose(fetch_valid_i) && fetch_ext_i |=>
      !fetch_done_o [*3] ##1 fetch_done_o;
  endproperty
  a_ext_fetch: assert property (p_ext_fetch)
    else $error("external fetch not four clocks");
  property p_ale_int;
    fetch_valid_i && !fetch_ext_i && !ale_internal_en_i && !op_valid_i
      |=> !ale_o;
  endproperty
  a_ale_int: assert property (p_ale_int)
    else $error("latch strobe on internal fetch");
  property p_ale_ext;
    $rose(fetch_valid_i) && fetch_ext_i |-> ##[1:4] ale_o;
  endproperty
  a_ale_ext: assert property (p_ale_ext)
    else $error("no latch strobe on external fetch");
  property p_ale_opt;
    $rose(fetch_valid_i) && !fetch_ext_i && ale_internal_en_i |=> ale_o;
  endproperty
  a_ale_opt: assert property (p_ale_opt)
    else $error("latch strobe option ignored on internal fetch");
  property p_pss_ext;
    $rose(fetch_valid_i) && fetch_ext_i |-> ##[1:4] !program_store_strobe_n_o;
  endproperty
  a_pss_ext: assert property (p_pss_ext)
    else $error("no program strobe on external fetch");
  property p_pss_only;
    !program_store_strobe_n_o |-> fetch_ext_i && rd_n_o && wr_n_o;
  endproperty
  a_pss_only: assert property (p_pss_only)
    else $error("program strobe outside external fetch");
endmodule
bind mxmem_top mxmem_top_monitor u_mon (.sys_clk_i, .rst_i, .psel,
  .penable, .pwrite, .paddr, .pwdata, .op_valid_i, .op_code_i,
  .fetch_valid_i, .fetch_ext_i, .ale_internal_en_i, .op_done_o, .dptr_o,
  .fetch_done_o, .ale_o, .rd_n_o, .wr_n_o, .program_store_strobe_n_o);
`default_nettype wire

/* verif/testbench.sv */
// Purpose: register, pointer and bus timing tests of the data-memory block
// Assumes: APB read data taken at the edge that completes the access
// Notes:   external byte memory model stands on the data bus
`default_nettype none
`include "mxmem_cfg.svh"
module testbench
  import mxmem_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk_i, rst_i, psel, penable, pwrite, pready, pslverr;
  logic        op_valid_i, fetch_valid_i, fetch_ext_i, ale_internal_en_i;
  logic        op_done_o, fetch_done_o, ext_data_oe_o, ale_o, rd_n_o;
  logic        wr_n_o, program_store_strobe_n_o, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0]  op_code_i;
  logic [15:0] op_data_i, dptr_o, ext_addr_o;
  logic [7:0]  op_wdata_i, op_rdata_o, ext_data_o, ext_data_i;
  int          mismatches, n_compared, n, n0;
  localparam int STR [8] = '{0, 1, 2, 3, 7, 8, 9, 10};
  mxmem_top #(.AW(16)) dut (.sys_clk_i, .rst_i, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .op_valid_i, .op_code_i,
    .op_data_i, .op_wdata_i, .fetch_valid_i, .fetch_ext_i,
    .ale_internal_en_i, .op_done_o, .op_rdata_o, .dptr_o, .fetch_done_o,
    .ext_addr_o, .ext_data_o, .ext_data_oe_o, .ext_data_i, .ale_o,
    .rd_n_o, .wr_n_o, .program_store_strobe_n_o);
  mxmem_ext_ram u_ram (.sys_clk_i, .slow_i(slow), .addr_i(ext_addr_o),
    .data_i(ext_data_o), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o),
    .data_o(ext_data_i));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    @(posedge sys_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk_i);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q, exp);
  endtask
  task automatic op(input mxmem_op_type c, input logic [15:0] d,
                    input logic [7:0] w);
    @(posedge sys_clk_i);
    op_valid_i <= 1'b1;
    op_code_i <= c;
    op_data_i <= d;
    op_wdata_i <= w;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      #1 n++;
    end while (op_done_o !== 1'b1);
    @(posedge sys_clk_i);
    op_valid_i <= 1'b0;
  endtask
  task automatic fetch(input logic ext, input logic ale_en);
    @(posedge sys_clk_i);
    fetch_valid_i <= 1'b1;
    fetch_ext_i <= ext;
    ale_internal_en_i <= ale_en;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      #1 n++;
    end while (fetch_done_o !== 1'b1);
    @(posedge sys_clk_i);
    fetch_valid_i <= 1'b0;
  endtask
  task automatic close_out();
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    mismatches++;
    close_out();
  end
  initial begin
    logic [31:0] q;
    logic        e;
    int          x;
    {rst_i, psel, penable, pwrite, paddr, pwdata, slow} = '0;
    {op_valid_i, op_code_i, op_data_i, op_wdata_i} = '0;
    {fetch_valid_i, fetch_ext_i, ale_internal_en_i} = '0;
    mismatches = 0;
    n_compared = 0;
    rst_i = 1'b1;
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(`MXMEM_OFF_BUS_TIMING, 32'h0000_0001);
    rd(`MXMEM_OFF_PTR_SELECT, 32'h0000_0000);
    rd(`MXMEM_OFF_POWER_MGMT, 32'h0000_0000);
    apb(1'b0, 12'h0ffc, 32'h0000_0000, q, e);
    chk(e, 32'h0000_0001);
    op(MXMEM_OP_MOVDP, 16'h0010, 8'h00);
    op(MXMEM_OP_MOVX_WR, 16'h0000, 8'ha5);
    chk(u_ram.mem[16'h0010], 32'h0000_00a5);
    wr(`MXMEM_OFF_POWER_MGMT, 32'h0000_0003);
    op(MXMEM_OP_MOVDP, 16'h03ff, 8'h00);
    op(MXMEM_OP_MOVX_WR, 16'h0000, 8'h3c);
    chk(n, 1);
    op(MXMEM_OP_MOVX_RD, 16'h0000, 8'h00);
    chk(op_rdata_o, 32'h0000_003c);
    chk(u_ram.mem[16'h03ff], 32'h0000_0000);
    op(MXMEM_OP_MOVDP, 16'h0400, 8'h00);
    op(MXMEM_OP_MOVX_WR, 16'h0000, 8'h5a);
    chk(u_ram.mem[16'h0400], 32'h0000_005a);
    for (int i = 0; i < 8; i++) begin
      wr(`MXMEM_OFF_PTR_SELECT, {24'h0, i[2:1], 5'h0, i[0]});
      op(MXMEM_OP_MOVDP, 16'h1000, 8'h00);
      op(MXMEM_OP_INC, 16'h0000, 8'h00);
      chk(dptr_o, (i[0] ? i[2] : i[1]) ? 32'h0fff : 32'h1001);
    end
    wr(`MXMEM_OFF_PTR_SELECT, 32'h0000_0020);
    wr(`MXMEM_OFF_PTR0, 32'h0000_2222);
    wr(`MXMEM_OFF_PTR1, 32'h0000_0333);
    for (int i = 1; i < 6; i++) begin
      op(mxmem_op_type'(i), 16'h0333, 8'h11);
      chk(dptr_o, i[0] ? 32'h0333 : 32'h2223);
    end
    rd(`MXMEM_OFF_PTR_SELECT, 32'h0000_0021);
    for (int i = 0; i < 2; i++) begin
      wr(`MXMEM_OFF_PTR_SELECT, i ? 32'h0000_0050 : 32'h0000_0010);
      for (int c = 2; c < 6; c++) begin
        op(mxmem_op_type'(c), 16'h0100, 8'h22);
        x = 256 + (i ? 2 - c : c - 2);
        chk(dptr_o, x);
      end
    end
    wr(`MXMEM_OFF_POWER_MGMT, 32'h0000_0000);
    wr(`MXMEM_OFF_PTR_SELECT, 32'h0000_0000);
    wr(`MXMEM_OFF_PTR0, 32'h0000_0500);
    for (int k = 0; k < 8; k++) begin
      wr(`MXMEM_OFF_BUS_TIMING, k);
      op(MXMEM_OP_MOVX_WR, 16'h0000, k[7:0]);
      if (k == 0) n0 = n;
      chk(n - n0, 4 * STR[k]);
    end
    chk(n0, 2 * `MXMEM_EXT_CLKS + 1);
    chk(u_ram.mem[16'h0500], 32'h0000_0007);
    wr(`MXMEM_OFF_BUS_TIMING, 32'h0000_0004);
    slow <= 1'b1;
    op(MXMEM_OP_MOVX_RD, 16'h0000, 8'h00);
    chk(op_rdata_o, 32'h0000_0007);
    slow <= 1'b0;
    wr(`MXMEM_OFF_BUS_TIMING, 32'h0000_0007);
    wr(`MXMEM_OFF_POWER_MGMT, 32'h0000_0001);
    wr(`MXMEM_OFF_PTR0, 32'h0000_0100);
    op(MXMEM_OP_MOVX_WR, 16'h0000, 8'h00);
    chk(n, 1);
    fetch(1'b1, 1'b0);
    chk(n, 4);
    fetch(1'b0, 1'b0);
    chk(n, 1);
    fetch(1'b0, 1'b1);
    chk(n, 1);
    close_out();
  end
endmodule
`default_nettype wire
